// ---- pkg/fcf_defines.svh ----
// Offsets, fields, reset values and timing counts of the feedback block
`ifndef FCF_DEFINES_SVH
`define FCF_DEFINES_SVH
`define FCF_CLK_PERIOD_NS 20
`define FCF_OVS_WIN_NS 5000
`define FCF_OVS_WIN_CYC (`FCF_OVS_WIN_NS / `FCF_CLK_PERIOD_NS)
`define FCF_OVS_RATE_KPPS 6400
`define FCF_OVS_MAX_EDGES (`FCF_OVS_RATE_KPPS * `FCF_OVS_WIN_NS / 1000000)
`define FCF_ADR_CFG 8'h00
`define FCF_ADR_PITCH 8'h04
`define FCF_ADR_RES 8'h08
`define FCF_ADR_DEVLIM 8'h0c
`define FCF_ADR_MULT 8'h10
`define FCF_ADR_CTRL 8'h14
`define FCF_ADR_STATUS 8'h18
`define FCF_ADR_CODE 8'h1c
`define FCF_ADR_FBCNT 8'h20
`define FCF_ADR_DEV 8'h24
`define FCF_CFG_DIR_BIT 0
`define FCF_CFG_USE_LSB 4
`define FCF_CFG_USE_MSB 6
`define FCF_ST_OVS_BIT 0
`define FCF_ST_DEV_BIT 1
`define FCF_USE_NONE 3'h0
`define FCF_USE_CCW_FWD 3'h1
`define FCF_USE_CCW_REV 3'h3
`define FCF_PITCH_DEF 21'h008000
`define FCF_PITCH_MIN 21'h000004
`define FCF_PITCH_MAX 21'h100000
`define FCF_RES_DEF 13'h0014
`define FCF_RES_MIN 13'h0001
`define FCF_RES_MAX 13'h1000
`define FCF_DEVLIM_DEF 30'h000003e8
`define FCF_MULT_DEF 7'h14
`define FCF_MULT_MAX 7'h64
`define FCF_PCT_FULL 40'sh64
`define FCF_CODE_NONE 8'h00
`define FCF_CODE_OVS 8'h01
`define FCF_CODE_DEV 8'h02
`endif

// ---- pkg/fcf_pkg.sv ----
// Types shared by the feedback block
package fcf_pkg;
    typedef enum logic [1:0] {FCF_QS0, FCF_QS1, FCF_QS2, FCF_QS3} fcf_qstate_t;
    typedef logic signed [31:0] fcf_pos_t;
endpackage

// ---- pkg/fcf_step_if.sv ----
// Step and direction pair passed between the block's modules
interface fcf_step_if;
    logic step;
    logic up;
    modport src (output step, output up);
    modport snk (input step, input up);
endinterface

// ---- core/fcf_quad_in.sv ----
// Quadrature decoder for the external encoder pins
module fcf_quad_in (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Sync reset, high
    input wire logic a_i,   // Encoder phase A pin
    input wire logic b_i,   // Encoder phase B pin
    fcf_step_if.src st_o    // Decoded step, up when A leads
);
    logic [1:0] meta_reg;
    logic [1:0] sync_reg;
    logic [1:0] prev_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 2'h0;
            sync_reg <= 2'h0;
            prev_reg <= 2'h0;
        end else begin
            meta_reg <= {a_i, b_i};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Exactly one phase changed; double changes are dropped
    assign st_o.step = (sync_reg[1] ^ prev_reg[1]) ^ (sync_reg[0] ^ prev_reg[0]);
    assign st_o.up = prev_reg[0] ^ sync_reg[1];
endmodule

// ---- core/fcf_div_out.sv ----
// Divided quadrature output generator with output rate watch
`include "fcf_defines.svh"
module fcf_div_out (
    input wire logic clk_i,         // System clock
    input wire logic rst_i,         // Sync reset, high
    fcf_step_if.snk st_i,           // Load step, up means forward reference
    input wire logic [12:0] res_i,  // Edges per scale pitch
    output logic pa_o,              // Divided phase A
    output logic pb_o,              // Divided phase B
    output logic ovs_o              // Output rate too high, one-cycle pulse
);
    localparam int WIN = `FCF_OVS_WIN_CYC;
    localparam int MAXE = `FCF_OVS_MAX_EDGES;
    fcf_pkg::fcf_qstate_t q_reg;
    logic signed [23:0] pend_reg;
    logic [15:0] win_reg;
    logic [15:0] edges_reg;
    logic pa_reg;
    logic pb_reg;
    logic ovs_reg;

    function automatic fcf_pkg::fcf_qstate_t q_step(input fcf_pkg::fcf_qstate_t q,
                                                     input logic fwd);
        case (q)
            fcf_pkg::FCF_QS0: q_step = fwd ? fcf_pkg::FCF_QS1 : fcf_pkg::FCF_QS3;
            fcf_pkg::FCF_QS1: q_step = fwd ? fcf_pkg::FCF_QS2 : fcf_pkg::FCF_QS0;
            fcf_pkg::FCF_QS2: q_step = fwd ? fcf_pkg::FCF_QS3 : fcf_pkg::FCF_QS1;
            fcf_pkg::FCF_QS3: q_step = fwd ? fcf_pkg::FCF_QS0 : fcf_pkg::FCF_QS2;
            default: q_step = fcf_pkg::FCF_QS0;
        endcase
    endfunction

    wire signed [23:0] res_s = {11'h000, res_i};
    wire signed [23:0] add = st_i.step ? (st_i.up ? res_s : -res_s) : 24'sh0;
    wire emit = pend_reg != 24'sh0;
    wire emit_fwd = !pend_reg[23];
    wire signed [23:0] dec = emit ? (emit_fwd ? 24'sh1 : -24'sh1) : 24'sh0;
    wire fcf_pkg::fcf_qstate_t q_next = emit ? q_step(q_reg, emit_fwd) : q_reg;
    // Forward order 00,01,11,10 in (A,B): B leads A
    wire pa_next = (q_next == fcf_pkg::FCF_QS2) || (q_next == fcf_pkg::FCF_QS3);
    wire pb_next = (q_next == fcf_pkg::FCF_QS1) || (q_next == fcf_pkg::FCF_QS2);
    wire win_end = win_reg == 16'(WIN - 1);
    wire over = emit && (edges_reg == 16'(MAXE));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg <= fcf_pkg::FCF_QS0;
            pend_reg <= 24'sh0;
            pa_reg <= 1'b0;
            pb_reg <= 1'b0;
            win_reg <= 16'h0;
            edges_reg <= 16'h0;
            ovs_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
            pend_reg <= pend_reg + add - dec;
            pa_reg <= pa_next;
            pb_reg <= pb_next;
            win_reg <= win_end ? 16'h0 : win_reg + 16'h1;
            edges_reg <= win_end ? 16'h0 : edges_reg + {15'h0, emit};
            ovs_reg <= over;
        end
    end

    assign pa_o = pa_reg;
    assign pb_o = pb_reg;
    assign ovs_o = ovs_reg;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rate_exceeded;
        emit && edges_reg == 16'(MAXE);
    endsequence
    AST_OVERSPEED: assert property (s_rate_exceeded |=> ovs_o)
        else $error("Output overspeed not flagged");
    AST_B_LEADS: assert property (emit && emit_fwd |=> q_reg == q_step($past(q_reg), 1'b1))
        else $error("Forward edge not in B-leading order");
    AST_SCALE: assert property (st_i.step && st_i.up && pend_reg == 24'sh0
                                |=> pend_reg == res_s)
        else $error("Pending edges not scaled by resolution");
endmodule

// ---- core/fcf_top.sv ----
// Fully-closed feedback block: direction map, counters, divided output, alarms
// Functional notes
// - Usage 0 none, 1 forward, 3 reverse
// - Direction select maps reference to motor, encoder
// - Forward reference gives B leading A
// - Feedback counter up forward, down reverse
// - Pitches 4 to 1048576, applied on restart
// - Resolution 1 to 4096, applied on restart
// - Output above 6.4 Mpps raises overspeed
// - Deviation above limit raises overflow alarm while the external encoder is in use
// - Deviation limit default 1000, immediate
// - Limit zero disables overflow alarm
// - Absolute position load as linear sequence
// - Each rotation carries deviation scaled by multiplier
`include "fcf_defines.svh"
module fcf_top (
    input wire logic clk_i,                 // System clock, 50 MHz
    input wire logic rst_i,                 // Sync reset, high
    input wire logic wb_cyc_i,              // Wishbone cycle
    input wire logic wb_stb_i,              // Wishbone strobe
    input wire logic wb_we_i,               // Wishbone write
    input wire logic [7:0] wb_adr_i,        // Wishbone byte address
    input wire logic [3:0] wb_sel_i,        // Wishbone byte selects
    input wire logic [31:0] wb_dat_i,       // Wishbone write data
    output logic [31:0] wb_dat_o,           // Wishbone read data
    output logic wb_ack_o,                  // Wishbone acknowledge
    input wire logic ext_a_i,               // External encoder phase A pin
    input wire logic ext_b_i,               // External encoder phase B pin
    input wire logic abs_load_i,            // Absolute position word valid
    input wire logic [31:0] abs_pos_i,      // Absolute position word
    input wire logic ref_fwd_i,             // Reference is forward
    input wire logic motor_step_i,          // Motor feedback step
    input wire logic motor_fwd_i,           // Motor step is forward
    output logic motor_ccw_o,               // Motor turns counterclockwise
    output logic ext_fwd_o,                 // Encoder expected to move forward
    output logic ext_used_o,                // External encoder in use
    output logic divided_phase_a_out_o,     // Divided phase A
    output logic divided_phase_b_out_o,     // Divided phase B
    output logic divided_phase_c_out_o,     // One pulse per rotation
    output logic alarm_o                    // Any alarm latched
);
    logic ack_reg;
    logic [31:0] dat_reg;
    logic dir_pend_reg;
    logic dir_act_reg;
    logic [2:0] use_pend_reg;
    logic [2:0] use_act_reg;
    logic [20:0] pitch_pend_reg;
    logic [20:0] pitch_act_reg;
    logic [12:0] res_pend_reg;
    logic [12:0] res_act_reg;
    logic [29:0] devlim_reg;
    logic [6:0] mult_reg;
    fcf_pkg::fcf_pos_t fb_cnt_reg;
    fcf_pkg::fcf_pos_t motor_pos_reg;
    fcf_pkg::fcf_pos_t load_pos_reg;
    fcf_pkg::fcf_pos_t off_reg;
    logic [20:0] rev_cnt_reg;
    logic abs_wait_reg;
    logic alm_ovs_reg;
    logic alm_dev_reg;
    logic pc_reg;
    logic ovs_pulse;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            old[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
        merge = old;
    endfunction

    function automatic fcf_pkg::fcf_pos_t pct(input fcf_pkg::fcf_pos_t d,
                                              input logic [6:0] m);
        logic signed [39:0] p;
        p = 40'(d) * $signed({33'h0, m});
        pct = 32'(p / `FCF_PCT_FULL);
    endfunction

    function automatic logic [31:0] mag(input fcf_pkg::fcf_pos_t d);
        mag = d[31] ? 32'(-d) : 32'(d);
    endfunction

    // Bus decode
    wire req = wb_cyc_i && wb_stb_i;
    wire wb_wr = req && wb_we_i && ack_reg;
    wire wr_cfg = wb_wr && (wb_adr_i == `FCF_ADR_CFG);
    wire wr_pitch = wb_wr && (wb_adr_i == `FCF_ADR_PITCH);
    wire wr_res = wb_wr && (wb_adr_i == `FCF_ADR_RES);
    wire wr_devlim = wb_wr && (wb_adr_i == `FCF_ADR_DEVLIM);
    wire wr_mult = wb_wr && (wb_adr_i == `FCF_ADR_MULT);
    wire wr_ctrl = wb_wr && (wb_adr_i == `FCF_ADR_CTRL);
    wire wr_stat = wb_wr && (wb_adr_i == `FCF_ADR_STATUS) && wb_sel_i[0];
    wire restart = wr_ctrl && wb_sel_i[0] && wb_dat_i[0];

    // Write values after byte merge and range limiting
    wire [31:0] cfg_old = {25'h0, use_pend_reg, 3'h0, dir_pend_reg};
    wire [31:0] cfg_w = merge(cfg_old, wb_dat_i, wb_sel_i);
    wire [2:0] use_w = cfg_w[`FCF_CFG_USE_MSB:`FCF_CFG_USE_LSB];
    wire use_ok = (use_w == `FCF_USE_NONE) || (use_w == `FCF_USE_CCW_FWD)
                  || (use_w == `FCF_USE_CCW_REV);
    wire [31:0] pitch_w = merge({11'h0, pitch_pend_reg}, wb_dat_i, wb_sel_i);
    wire [20:0] pitch_c = (pitch_w < {11'h0, `FCF_PITCH_MIN}) ? `FCF_PITCH_MIN
                        : (pitch_w > {11'h0, `FCF_PITCH_MAX}) ? `FCF_PITCH_MAX
                        : pitch_w[20:0];
    wire [31:0] res_w = merge({19'h0, res_pend_reg}, wb_dat_i, wb_sel_i);
    wire [12:0] res_c = (res_w < {19'h0, `FCF_RES_MIN}) ? `FCF_RES_MIN
                      : (res_w > {19'h0, `FCF_RES_MAX}) ? `FCF_RES_MAX
                      : res_w[12:0];
    wire [31:0] devlim_w = merge({2'h0, devlim_reg}, wb_dat_i, wb_sel_i);
    wire [31:0] mult_w = merge({25'h0, mult_reg}, wb_dat_i, wb_sel_i);
    wire [6:0] mult_c = (mult_w > {25'h0, `FCF_MULT_MAX}) ? `FCF_MULT_MAX : mult_w[6:0];

    // Direction mapping
    wire ext_used = use_act_reg != `FCF_USE_NONE;
    wire ext_fwd_ref = dir_act_reg == (use_act_reg == `FCF_USE_CCW_REV);
    fcf_step_if qst ();
    fcf_step_if ldst ();
    fcf_quad_in u_quad (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .a_i(ext_a_i),
        .b_i(ext_b_i),
        .st_o(qst)
    );
    wire ext_step = ext_used && qst.step;
    assign ldst.step = ext_step;
    assign ldst.up = qst.up == ext_fwd_ref;

    fcf_div_out u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .st_i(ldst),
        .res_i(res_act_reg),
        .pa_o(divided_phase_a_out_o),
        .pb_o(divided_phase_b_out_o),
        .ovs_o(ovs_pulse)
    );

    // Positions and deviation
    wire fcf_pkg::fcf_pos_t ld_d = ldst.up ? 32'sh1 : -32'sh1;
    wire fcf_pkg::fcf_pos_t mt_d = motor_fwd_i ? 32'sh1 : -32'sh1;
    wire fcf_pkg::fcf_pos_t dev = motor_pos_reg - load_pos_reg - off_reg;
    wire rev_evt = ext_step && (rev_cnt_reg == pitch_act_reg - 21'h1);
    wire dev_over = mag(dev) > {2'h0, devlim_reg};
    wire dev_set = dev_over && (devlim_reg != 30'h0) && ext_used;
    wire abs_take = abs_load_i && abs_wait_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ack_reg <= req && !ack_reg;
            if (req && !ack_reg) begin
                case (wb_adr_i)
                    `FCF_ADR_CFG: dat_reg <= cfg_old;
                    `FCF_ADR_PITCH: dat_reg <= {11'h0, pitch_pend_reg};
                    `FCF_ADR_RES: dat_reg <= {19'h0, res_pend_reg};
                    `FCF_ADR_DEVLIM: dat_reg <= {2'h0, devlim_reg};
                    `FCF_ADR_MULT: dat_reg <= {25'h0, mult_reg};
                    `FCF_ADR_STATUS: dat_reg <= {30'h0, alm_dev_reg, alm_ovs_reg};
                    `FCF_ADR_CODE: dat_reg <= {24'h0, alm_dev_reg ? `FCF_CODE_DEV
                                      : alm_ovs_reg ? `FCF_CODE_OVS : `FCF_CODE_NONE};
                    `FCF_ADR_FBCNT: dat_reg <= fb_cnt_reg;
                    `FCF_ADR_DEV: dat_reg <= dev;
                    default: dat_reg <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_pend_reg <= 1'b0;
            use_pend_reg <= `FCF_USE_NONE;
            pitch_pend_reg <= `FCF_PITCH_DEF;
            res_pend_reg <= `FCF_RES_DEF;
            devlim_reg <= `FCF_DEVLIM_DEF;
            mult_reg <= `FCF_MULT_DEF;
        end else begin
            if (wr_cfg) begin
                dir_pend_reg <= cfg_w[`FCF_CFG_DIR_BIT];
                use_pend_reg <= use_ok ? use_w : use_pend_reg;
            end
            if (wr_pitch) begin
                pitch_pend_reg <= pitch_c;
            end
            if (wr_res) begin
                res_pend_reg <= res_c;
            end
            if (wr_devlim) begin
                devlim_reg <= devlim_w[29:0];
            end
            if (wr_mult) begin
                mult_reg <= mult_c;
            end
        end
    end

    // Restart settings take effect only here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_act_reg <= 1'b0;
            use_act_reg <= `FCF_USE_NONE;
            pitch_act_reg <= `FCF_PITCH_DEF;
            res_act_reg <= `FCF_RES_DEF;
        end else if (restart) begin
            dir_act_reg <= dir_pend_reg;
            use_act_reg <= use_pend_reg;
            pitch_act_reg <= pitch_pend_reg;
            res_act_reg <= res_pend_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || restart) begin
            fb_cnt_reg <= 32'sh0;
            motor_pos_reg <= 32'sh0;
            load_pos_reg <= 32'sh0;
            off_reg <= 32'sh0;
            rev_cnt_reg <= 21'h0;
            abs_wait_reg <= 1'b1;
            pc_reg <= 1'b0;
        end else begin
            if (abs_take) begin
                fb_cnt_reg <= abs_pos_i;
                abs_wait_reg <= 1'b0;
            end else if (ext_step) begin
                fb_cnt_reg <= fb_cnt_reg + (qst.up ? 32'sh1 : -32'sh1);
                abs_wait_reg <= 1'b0;
            end
            if (ext_step) begin
                load_pos_reg <= load_pos_reg + ld_d;
                rev_cnt_reg <= rev_evt ? 21'h0 : rev_cnt_reg + 21'h1;
            end
            if (motor_step_i) begin
                motor_pos_reg <= motor_pos_reg + mt_d;
            end
            if (rev_evt) begin
                off_reg <= off_reg + pct(dev, mult_reg);
            end
            pc_reg <= rev_evt;
        end
    end

    // Alarms latch; a new event beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alm_ovs_reg <= 1'b0;
            alm_dev_reg <= 1'b0;
        end else begin
            alm_ovs_reg <= (alm_ovs_reg && !(wr_stat && wb_dat_i[`FCF_ST_OVS_BIT]))
                           || ovs_pulse;
            alm_dev_reg <= (alm_dev_reg && !(wr_stat && wb_dat_i[`FCF_ST_DEV_BIT]))
                           || dev_set;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign motor_ccw_o = ref_fwd_i ^ dir_act_reg;
    assign ext_fwd_o = ref_fwd_i == ext_fwd_ref;
    assign ext_used_o = ext_used;
    assign divided_phase_c_out_o = pc_reg;
    assign alarm_o = alm_ovs_reg || alm_dev_reg;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_USE_DECODE: assert property (ext_used_o == (use_act_reg != 3'h0))
        else $error("Usage decode wrong");
    AST_MOTOR_DIR: assert property (ref_fwd_i && !dir_act_reg |-> motor_ccw_o)
        else $error("Forward reference not counterclockwise");
    AST_EXT_DIR: assert property (ext_step && qst.up && dir_act_reg
                                  && use_act_reg == 3'h3 && !restart
                                  |=> load_pos_reg == $past(load_pos_reg) + 32'sh1)
        else $error("Encoder forward not mapped to forward reference");
    AST_FB_UP: assert property (ext_step && qst.up && !abs_take && !restart
                                |=> fb_cnt_reg == $past(fb_cnt_reg) + 32'sh1)
        else $error("Counter did not count up");
    AST_FB_DN: assert property (ext_step && !qst.up && !abs_take && !restart
                                |=> fb_cnt_reg == $past(fb_cnt_reg) - 32'sh1)
        else $error("Counter did not count down");
    AST_PITCH_HOLD: assert property (!restart |=> $stable(pitch_act_reg))
        else $error("Pitch count changed without restart");
    AST_RES_HOLD: assert property (!restart |=> $stable(res_act_reg))
        else $error("Resolution changed without restart");
    AST_DEV_SET: assert property (dev_over && devlim_reg != 30'h0 && ext_used
                                  |=> alm_dev_reg)
        else $error("Deviation overflow not flagged");
    AST_LIM_NOW: assert property (wr_devlim && wb_sel_i == 4'hf
                                  |=> devlim_reg == $past(wb_dat_i[29:0]))
        else $error("Deviation limit not applied at once");
    AST_DEV_OFF: assert property (devlim_reg == 30'h0 && !alm_dev_reg |=> !alm_dev_reg)
        else $error("Alarm raised with zero limit");
    AST_CARRY_ZERO: assert property (rev_evt && mult_reg == 7'h0 && !restart
                                     |=> $stable(off_reg))
        else $error("Zero multiplier changed deviation");
    AST_LATCH: assert property (alm_dev_reg && !wr_stat |=> alm_dev_reg)
        else $error("Alarm dropped without clear");
endmodule

// ---- test/fcf_enc_model.sv ----
// External incremental encoder model: one quadrature change per step request
module fcf_enc_model (
    input wire logic clk_i,  // System clock
    input wire logic rst_i,  // Sync reset, high
    input wire logic step_i, // Move one count
    input wire logic fwd_i,  // Forward move, A leads B
    output logic a_o,        // Phase A pin
    output logic b_o         // Phase B pin
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk_i) begin
        if (rst_i) begin
            a_o <= 1'b0;
            b_o <= 1'b0;
        end else if (step_i && fwd_i) begin
            a_o <= ~b_o;
            b_o <= a_o;
        end else if (step_i) begin
            a_o <= b_o;
            b_o <= ~a_o;
        end
    end
endmodule

// ---- test/fcf_tb_top.sv ----
// Self-checking bench of the fully-closed feedback block
`include "fcf_defines.svh"
module fcf_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, ref_fwd = 1;
    logic mot_step = 0, mot_fwd = 1, enc_step = 0, enc_fwd = 1, enc_a, enc_b, abs_ld = 0;
    logic ccw, efwd, used, pa, pb, pc, alarm;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat_w = 32'h0, dat_r, q;
    logic [1:0] prev = 2'h0;
    int bad_count = 0, check_count = 0, cycles = 0, fwd_edges = 0, rev_edges = 0;
    int pc_count = 0;
    fcf_enc_model fcf_enc_model_inst (.clk_i(clk_i), .rst_i(rst_i), .step_i(enc_step),
        .fwd_i(enc_fwd), .a_o(enc_a), .b_o(enc_b));
    fcf_top fcf_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .ext_a_i(enc_a), .ext_b_i(enc_b), .abs_load_i(abs_ld),
        .abs_pos_i(32'h123), .ref_fwd_i(ref_fwd), .motor_step_i(mot_step),
        .motor_fwd_i(mot_fwd), .motor_ccw_o(ccw), .ext_fwd_o(efwd), .ext_used_o(used),
        .divided_phase_a_out_o(pa), .divided_phase_b_out_o(pb),
        .divided_phase_c_out_o(pc), .alarm_o(alarm));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // Divided edges sorted by which phase leads
    always @(posedge clk_i) begin
        prev <= {pa, pb};
        cycles <= cycles + 1;
        if ({pa, pb} != prev && {pa, pb} == {prev[0], ~prev[1]}) fwd_edges <= fwd_edges + 1;
        else if ({pa, pb} != prev) rev_edges <= rev_edges + 1;
        if (pc) pc_count <= pc_count + 1;
        if (cycles == 30000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 40) chk(1'b0, 1'b1, "no ack");
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
        wb(1'b0, a, 32'h0);
        chk(q, e, m);
    endtask
    task automatic pulse(input logic enc, input logic fwd, input int n);
        repeat (n) begin
            @(posedge clk_i);
            if (enc) enc_step <= 1'b1;
            else mot_step <= 1'b1;
            enc_fwd <= fwd;
            mot_fwd <= fwd;
            @(posedge clk_i);
            enc_step <= 1'b0;
            mot_step <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        repeat (30) @(posedge clk_i);
    endtask
    task automatic t_defaults();
        rd_chk(`FCF_ADR_PITCH, 32'h8000, "pitch default");
        rd_chk(`FCF_ADR_RES, 32'h14, "res default");
        rd_chk(`FCF_ADR_DEVLIM, 32'h3e8, "limit default");
        rd_chk(`FCF_ADR_MULT, 32'h14, "mult default");
        chk(used, 1'b0, "usage default");
        wb(1'b1, `FCF_ADR_PITCH, 32'h3);
        rd_chk(`FCF_ADR_PITCH, 32'h4, "pitch floor");
        wb(1'b1, `FCF_ADR_RES, 32'h0);
        rd_chk(`FCF_ADR_RES, 32'h1, "res floor");
        wb(1'b1, `FCF_ADR_PITCH, 32'h8000);
    endtask
    task automatic t_direction();
        logic [2:0] cur;
        cur = 3'h0;
        for (int u = 0; u < 5; u++) begin
            for (int d = 0; d < 2; d++) begin
                wb(1'b1, `FCF_ADR_CFG, (u << 4) | d);
                wb(1'b1, `FCF_ADR_CTRL, 32'h1);
                if (u != 2 && u != 4) cur = u[2:0];
                @(posedge clk_i);
                chk(used, cur != 3'h0, "usage decode");
                for (int r = 0; r < 2; r++) begin
                    ref_fwd <= r[0];
                    @(posedge clk_i);
                    #1 chk(ccw, r[0] ^ d[0], "motor sense");
                    if (cur != 3'h0) chk(efwd, r[0] == (d[0] == (cur == 3'h3)), "enc sense");
                end
            end
        end
        ref_fwd <= 1'b1;
    endtask
    task automatic t_count(input logic [31:0] cfg);
        wb(1'b1, `FCF_ADR_CFG, cfg);
        wb(1'b1, `FCF_ADR_RES, 32'h4);
        wb(1'b1, `FCF_ADR_CTRL, 32'h1);
        fwd_edges = 0;
        rev_edges = 0;
        pulse(1'b1, 1'b1, 3);
        chk(fwd_edges, 12, "edges B leading");
        chk(rev_edges, 0, "edges A leading");
        rd_chk(`FCF_ADR_FBCNT, 32'h3, "count up");
        pulse(1'b1, 1'b0, 1);
        rd_chk(`FCF_ADR_FBCNT, 32'h2, "count down");
    endtask
    task automatic t_overspeed();
        wb(1'b1, `FCF_ADR_RES, 32'h1000);
        wb(1'b1, `FCF_ADR_CTRL, 32'h1);
        chk(alarm, 1'b0, "quiet before");
        pulse(1'b1, 1'b1, 1);
        repeat (4200) @(posedge clk_i);
        chk(alarm, 1'b1, "overspeed latched");
        rd_chk(`FCF_ADR_STATUS, 32'h1, "overspeed flag");
        rd_chk(`FCF_ADR_CODE, 32'h1, "overspeed code");
        wb(1'b1, `FCF_ADR_STATUS, 32'h1);
        rd_chk(`FCF_ADR_STATUS, 32'h0, "flag cleared");
    endtask
    task automatic t_deviation();
        wb(1'b1, `FCF_ADR_CTRL, 32'h1);
        wb(1'b1, `FCF_ADR_DEVLIM, 32'h2);
        pulse(1'b0, 1'b1, 2);
        chk(alarm, 1'b0, "at limit");
        pulse(1'b0, 1'b1, 1);
        chk(alarm, 1'b1, "over limit");
        rd_chk(`FCF_ADR_DEV, 32'h3, "deviation value");
        rd_chk(`FCF_ADR_CODE, 32'h2, "deviation code");
        wb(1'b1, `FCF_ADR_DEVLIM, 32'h0);
        wb(1'b1, `FCF_ADR_STATUS, 32'h2);
        pulse(1'b0, 1'b1, 5);
        chk(alarm, 1'b0, "limit zero off");
    endtask
    task automatic t_rotation();
        wb(1'b1, `FCF_ADR_PITCH, 32'h4);
        wb(1'b1, `FCF_ADR_CTRL, 32'h1);
        abs_ld <= 1'b1;
        @(posedge clk_i);
        abs_ld <= 1'b0;
        rd_chk(`FCF_ADR_FBCNT, 32'h123, "absolute preset");
        pulse(1'b0, 1'b1, 10);
        pulse(1'b1, 1'b1, 4);
        chk(pc_count, 1, "rotation pulse");
        rd_chk(`FCF_ADR_DEV, 32'h5, "carried deviation");
        wb(1'b1, `FCF_ADR_MULT, 32'h0);
        pulse(1'b1, 1'b1, 4);
        chk(pc_count, 2, "second rotation pulse");
        rd_chk(`FCF_ADR_DEV, 32'h1, "zero multiplier");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_defaults();
        t_direction();
        t_count(32'h10);
        t_count(32'h31);
        t_overspeed();
        t_deviation();
        t_rotation();
        end_sim();
    end
endmodule
